// *** bench/srcc_assertions.sv ***
// assertion checker bound to the reset class controller top
`timescale 1ns/1ps
`include "srcc_defs.svh"
module srcc_top_chk #(
  parameter int unsigned CPU_DLY_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic power_good_in,
  input wire logic platform_reset_in_b,
  input wire logic bus_reinit_signal_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic processor_reset_out_b,
  input wire logic core_reset_b,
  input wire logic fsb_arb_reset,
  input wire logic txn_flush,
  input wire logic refresh_en,
  input wire srcc_pkg::srcc_port_sts_t [`SRCC_NPORTS-1:0] port_sts
);
  import srcc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [15:0] low_q;
  logic [15:0] low_d;
  // cycles the processor has been held since platform reset went away
  always_comb begin
    if (processor_reset_out_b || !platform_reset_in_b || !power_good_in) begin
      low_d = 16'h0000;
    end else begin
      low_d = low_q + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    low_q <= rst_b ? low_d : 16'h0000;
  end
  // *****************************************
  // reset classes
  // *****************************************
  a_pg_low_reset: assert property (
    !power_good_in [*6] |-> !core_reset_b && !processor_reset_out_b)
    else $error("power-good low without reset");
  a_platform_reset_in_cpu_held: assert property (
    !platform_reset_in_b [*6] |-> !processor_reset_out_b && !core_reset_b)
    else $error("platform reset low but processor runs");
  // sync latency makes the release land late but in a fixed window
  a_core_release_delay: assert property (
    $rose(platform_reset_in_b) && power_good_in
      |-> !core_reset_b [*4] ##[1:8] core_reset_b)
    else $error("core reset release out of window");
  // pin sync and the hard-state step add up to three cycles to the timer
  a_cpu_release_delay: assert property (
    $rose(processor_reset_out_b) |-> low_q >= CPU_DLY_CYC - 2
      && low_q <= CPU_DLY_CYC + 4)
    else $error("processor reset pulse has wrong length");
  a_bus_reinit_signal_arb_reset: assert property (
    !bus_reinit_signal_b |=> fsb_arb_reset)
    else $error("bus-init without arbiter reset");
  a_bus_reinit_signal_flush_pulse: assert property (
    $fell(bus_reinit_signal_b) |=> txn_flush ##1 !txn_flush)
    else $error("bus-init flush pulse wrong");
  a_bus_reinit_signal_keeps_core: assert property (
    !bus_reinit_signal_b && core_reset_b |=> core_reset_b && refresh_en)
    else $error("bus-init disturbed core or refresh");
  a_apb_ready_pulse: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  for (genvar p = 0; p < `SRCC_NPORTS; p++) begin : g_port
    a_hard_ports_down: assert property (
      !core_reset_b |=> !port_sts[p].reset_b)
      else $error("port left up in hard reset");
    a_train_after_release: assert property (
      $rose(port_sts[p].train_en) |-> core_reset_b && power_good_in
        && port_sts[p].reset_b)
      else $error("port trains too early");
    a_link_after_train: assert property (
      $rose(port_sts[p].link_active) |-> port_sts[p].train_en)
      else $error("link active without training");
  end
  c_flush: cover property ($rose(txn_flush));
  c_targeted: cover property ($fell(port_sts[0].reset_b) && core_reset_b);
  c_cpu_only: cover property ($fell(processor_reset_out_b) && core_reset_b);
endmodule
bind srcc_top srcc_top_chk #(.CPU_DLY_CYC(CPU_DLY_CYC)) u_chk (
  .clk(clk), .rst_b(rst_b), .power_good_in(power_good_in),
  .platform_reset_in_b(platform_reset_in_b),
  .bus_reinit_signal_b(bus_reinit_signal_b), .psel(psel),
  .penable(penable), .pready(pready),
  .processor_reset_out_b(processor_reset_out_b),
  .core_reset_b(core_reset_b), .fsb_arb_reset(fsb_arb_reset),
  .txn_flush(txn_flush), .refresh_en(refresh_en), .port_sts(port_sts)
);

// *** bench/srcc_platform_model.sv ***
// power monitor, reset hub and link partners around the controller
`timescale 1ns/1ps
`include "srcc_defs.svh"
module srcc_platform_model #(
  parameter int PG_DLY   = 8,
  parameter int RST_DLY  = 10,
  parameter int LINK_DLY = 6
) (
  input  wire logic supply_ok,
  input  wire logic clk,
  input  wire logic hub_rst_req,
  input  wire srcc_pkg::srcc_port_sts_t [`SRCC_NPORTS-1:0] port_sts,
  output logic power_good_in,
  output logic platform_reset_in_b,
  output logic [`SRCC_NPORTS-1:0] link_up_in
);
  import srcc_pkg::*;
  int pg_cnt = 0;
  int hub_cnt = 0;
  int lnk_cnt [`SRCC_NPORTS];
  initial begin
    power_good_in = 1'b0;
    platform_reset_in_b = 1'b0;
    link_up_in = '0;
    lnk_cnt = '{default: 0};
  end
  // hub holds reset after power good; links only come up while trained
  always @(posedge clk) begin
    pg_cnt <= supply_ok ? pg_cnt + 1 : 0;
    power_good_in <= supply_ok && pg_cnt >= PG_DLY;
    hub_cnt <= (power_good_in && !hub_rst_req) ? hub_cnt + 1 : 0;
    platform_reset_in_b <= hub_cnt >= RST_DLY;
    for (int p = 0; p < `SRCC_NPORTS; p++) begin
      lnk_cnt[p] <= port_sts[p].train_en ? lnk_cnt[p] + 1 : 0;
      link_up_in[p] <= port_sts[p].train_en && lnk_cnt[p] >= LINK_DLY;
    end
  end
endmodule

// *** bench/tb_system_reset_class_controller.sv ***
// self-checking bench of the system reset class controller
`timescale 1ns/1ps
`include "srcc_defs.svh"
module tb_system_reset_class_controller;
  import srcc_pkg::*;
  localparam logic [11:0] P0 = 12'h400;
  localparam logic [11:0] P1 = 12'h800;
  localparam logic [11:0] BRC = 12'h0f8;
  localparam logic [11:0] LNK = 12'h11c;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic supply_ok = 1'b0;
  logic hub_rst_req = 1'b0;
  logic bus_reinit_signal_b = 1'b1;
  logic [3:0] err_event_in = 4'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic power_good_in, platform_reset_in_b, pready, pslverr;
  logic processor_reset_out_b, core_reset_b, fsb_arb_reset;
  logic txn_flush, refresh_en;
  logic [`SRCC_NPORTS-1:0] link_up_in;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic rs;
  srcc_port_sts_t [`SRCC_NPORTS-1:0] port_sts;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  srcc_top #(.CPU_DLY_CYC(20)) dut (.clk(clk), .rst_b(rst_b),
    .power_good_in(power_good_in), .platform_reset_in_b(platform_reset_in_b),
    .bus_reinit_signal_b(bus_reinit_signal_b), .err_event_in(err_event_in),
    .link_up_in(link_up_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txn_flush(txn_flush),
    .processor_reset_out_b(processor_reset_out_b), .port_sts(port_sts),
    .core_reset_b(core_reset_b), .fsb_arb_reset(fsb_arb_reset),
    .refresh_en(refresh_en));
  srcc_platform_model pm (.clk(clk), .supply_ok(supply_ok),
    .hub_rst_req(hub_rst_req), .port_sts(port_sts),
    .power_good_in(power_good_in), .link_up_in(link_up_in),
    .platform_reset_in_b(platform_reset_in_b));
  // *****************************************
  // shared tasks
  // *****************************************
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic chk1(input string w, input logic s, input logic e);
    chk(w, {31'h0, s}, {31'h0, e});
  endtask
  // apb master: request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no limit of its own: only the cycle ceiling ends this wait
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    rs = pslverr;
    chk1("apb answer", pready, 1'b1);
    chk("apb wait", n, 32'd2);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, rd, e);
    chk1("slverr", rs, 1'b0);
  endtask
  function automatic logic up(input int sel);
    if (sel == 0) return processor_reset_out_b === 1'b1;
    return port_sts[0].link_active === 1'b1 && port_sts[1].link_active === 1'b1;
  endfunction
  // bounded wait, so a stuck reset shows as a mismatch
  task automatic wait_up(input int sel);
    int n;
    n = 0;
    while (!up(sel) && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk1("wait", up(sel), 1'b1);
  endtask
  // *****************************************
  // scenarios
  // *****************************************
  task automatic t_power_off();
    repeat (8) @(posedge clk);
    chk1("cpu rst", processor_reset_out_b, 1'b0);
    chk1("port rst", port_sts[0].reset_b, 1'b0);
    chk1("refresh", refresh_en, 1'b0);
  endtask
  task automatic t_boot();
    supply_ok <= 1'b1;
    wait_up(0);
    chk1("core", core_reset_b, 1'b1);
    chk1("train", port_sts[0].train_en, 1'b0);
    rdc("err", 12'h008, 32'h0);
    rdc("brc", P1 + BRC, 32'h0);
    rdc("stat", 12'h004, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", {rs, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h000, 32'h0000000c);
    apb(1'b1, P1 + BRC, 32'h00000012);
    rdc("brc rw", P1 + BRC, 32'h00000012);
    wait_up(1);
    apb(1'b1, P0 + LNK, 32'h000000ff);
    rdc("lnk", P0 + LNK, 32'h00000002);
  endtask
  task automatic t_targeted();
    apb(1'b1, P0 + BRC, 32'h00000040);
    repeat (3) @(posedge clk);
    chk1("p0 rst", port_sts[0].reset_b, 1'b0);
    chk1("p0 link", port_sts[0].link_active, 1'b0);
    chk1("p1 link", port_sts[1].link_active, 1'b1);
    chk1("cpu", processor_reset_out_b, 1'b1);
    apb(1'b1, P0 + BRC, 32'h0);
    rdc("lnk low", P0 + LNK, 32'h0);
    wait_up(1);
    rdc("lnk up", P0 + LNK, 32'h00000002);
  endtask
  task automatic t_proc_only();
    apb(1'b1, 12'h000, 32'h0000000d);
    repeat (3) @(posedge clk);
    chk1("cpu", processor_reset_out_b, 1'b0);
    chk1("core", core_reset_b, 1'b1);
    chk1("link", port_sts[1].link_active, 1'b1);
    rdc("stat", 12'h004, 32'h00000001);
    wait_up(0);
  endtask
  task automatic t_bus_reinit_signal();
    bus_reinit_signal_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk1("flush", txn_flush, 1'b1);
    @(posedge clk);
    chk1("flush end", txn_flush, 1'b0);
    chk1("arb", fsb_arb_reset, 1'b1);
    chk1("refresh", refresh_en, 1'b1);
    bus_reinit_signal_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk1("links", up(1), 1'b1);
    rdc("brc kept", P1 + BRC, 32'h00000012);
  endtask
  task automatic t_hard_sticky();
    err_event_in <= 4'h5;
    @(posedge clk);
    err_event_in <= 4'h0;
    hub_rst_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk1("cpu", processor_reset_out_b, 1'b0);
    chk1("p1 rst", port_sts[1].reset_b, 1'b0);
    hub_rst_req <= 1'b0;
    wait_up(0);
    rdc("sticky", 12'h008, 32'h00000005);
    rdc("ctrl", 12'h000, 32'h0);
    rdc("brc", P1 + BRC, 32'h0);
    apb(1'b1, 12'h008, 32'h00000001);
    rdc("w1c", 12'h008, 32'h00000004);
    apb(1'b1, 12'h000, 32'h00000002);
    @(posedge clk);
    chk1("sw hard cpu", processor_reset_out_b, 1'b0);
    chk1("sw hard core", core_reset_b, 1'b0);
    wait_up(0);
    rdc("sticky sw", 12'h008, 32'h00000004);
    supply_ok <= 1'b0;
    repeat (10) @(posedge clk);
    supply_ok <= 1'b1;
    wait_up(0);
    rdc("err pg", 12'h008, 32'h0);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // cycle ceiling against a hung sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_power_off();
    t_boot();
    t_targeted();
    t_proc_only();
    t_bus_reinit_signal();
    t_hard_sticky();
    summarize();
  end
endmodule

// *** core/srcc_defs.svh ***
// constants of the system reset class controller
`ifndef SRCC_DEFS_SVH
`define SRCC_DEFS_SVH

// ***************************************************************
// timing
// ***************************************************************
`define SRCC_CLK_NS        25
`define SRCC_CPU_DLY_NS    1000000
`define SRCC_CORE_DLY_CYC  5
`define SRCC_CNT_W         16

// ***************************************************************
// sizes
// ***************************************************************
`define SRCC_NPORTS        2
`define SRCC_NERR          4

// ***************************************************************
// register map: global block and per-port blocks
// ***************************************************************
`define SRCC_CTRL_ADDR     12'h000
`define SRCC_STAT_ADDR     12'h004
`define SRCC_ERR_ADDR      12'h008
`define SRCC_BRCTL_IDX     8'h3e
`define SRCC_LNKSTS_IDX    8'h47

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define SRCC_CTRL_PROC_BIT 0
`define SRCC_CTRL_HARD_BIT 1
`define SRCC_CTRL_EN_LSB   2
`define SRCC_BRCTL_SBR_BIT 6
`define SRCC_LNK_ACT_BIT   1
`define SRCC_BRCTL_RST     16'h0000

`endif

// *** core/srcc_pkg.sv ***
// types of the system reset class controller
package srcc_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_POR,
    ST_HARD,
    ST_WAIT_CORE,
    ST_WAIT_CPU,
    ST_CPU_ONLY,
    ST_RUN
  } srcc_state_t;

  // software controls of one root port
  typedef struct packed {
    logic enable;
    logic sec_rst;
  } srcc_port_ctl_t;

  // state shown by one root port
  typedef struct packed {
    logic reset_b;
    logic train_en;
    logic link_active;
  } srcc_port_sts_t;

endpackage

// *** core/srcc_port.sv ***
// reset and training control of one root port
`timescale 1ns/1ps
module srcc_port (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    core_rst_b,
  input  wire logic                    pg_ok,
  input  wire srcc_pkg::srcc_port_ctl_t ctl,
  input  wire logic                    link_up,
  output srcc_pkg::srcc_port_sts_t      sts
);
  import srcc_pkg::*;

  srcc_port_sts_t sts_d;
  logic           wait_q;
  logic           wait_d;
  logic           up_prev_q;
  logic           up_prev_d;

  // downstream sees the same reset for hard and targeted cases
  always_comb begin
    sts_d.reset_b     = core_rst_b && !ctl.sec_rst;
    sts_d.train_en    = sts_d.reset_b && pg_ok && ctl.enable;
    up_prev_d         = link_up;
    wait_d            = wait_q;
    if (!sts_d.reset_b) begin
      wait_d = 1'b1;
    end else if (sts.train_en && link_up && !up_prev_q) begin
      wait_d = 1'b0;
    end
    // stale link-up from before the reset is never reported
    sts_d.link_active = sts.train_en && link_up && !wait_q;
  end

  // safe levels: port held in reset, no training
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sts       <= '0;
      wait_q    <= 1'b1;
      up_prev_q <= 1'b1;
    end else begin
      sts       <= sts_d;
      wait_q    <= wait_d;
      up_prev_q <= up_prev_d;
    end
  end

endmodule

// *** core/srcc_sync.sv ***
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module srcc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = d;
    q_d    = meta_q;
  end

  // resets to zero, which both inputs read as reset asserted
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule

// *** core/srcc_top.sv ***
// system reset class controller: sequencer, apb registers, root ports
`timescale 1ns/1ps
`include "srcc_defs.svh"
module srcc_top #(
  parameter int unsigned CPU_DLY_CYC = `SRCC_CPU_DLY_NS / `SRCC_CLK_NS
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      power_good_in,
  input  wire logic                      platform_reset_in_b,
  input  wire logic                      bus_reinit_signal_b,
  input  wire logic [`SRCC_NERR-1:0]     err_event_in,
  input  wire logic [`SRCC_NPORTS-1:0]   link_up_in,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           processor_reset_out_b,
  output logic                           core_reset_b,
  output logic                           fsb_arb_reset,
  output logic                           txn_flush,
  output logic                           refresh_en,
  output srcc_pkg::srcc_port_sts_t [`SRCC_NPORTS-1:0] port_sts
);
  import srcc_pkg::*;

  localparam int NP = `SRCC_NPORTS;
  localparam logic [`SRCC_CNT_W-1:0] CORE_END =
    `SRCC_CNT_W'(`SRCC_CORE_DLY_CYC - 1);
  localparam logic [`SRCC_CNT_W-1:0] CPU_END =
    `SRCC_CNT_W'(CPU_DLY_CYC - 1);

  // ***************************************************************
  // input synchronisation
  // ***************************************************************
  logic [1:0] sync_q;
  logic       pg_s;
  logic       platform_reset_in_s;

  // both pins have no relation to clk
  srcc_sync #(
    .W (2)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({power_good_in, platform_reset_in_b}),
    .q     (sync_q)
  );

  assign pg_s    = sync_q[1];
  assign platform_reset_in_s = sync_q[0];

  // ***************************************************************
  // reset sequencer
  // ***************************************************************
  srcc_state_t             st_q;
  srcc_state_t             st_d;
  logic [`SRCC_CNT_W-1:0]  cnt_q;
  logic [`SRCC_CNT_W-1:0]  cnt_d;
  logic                    cpu_rst_b_d;
  logic                    core_rst_b_d;
  logic                    refresh_d;
  logic                    proc_req_q;
  logic                    hard_req_q;

  // power-good wins over platform reset, which wins over software
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    if (!pg_s) begin
      st_d  = ST_POR;
      cnt_d = '0;
    end else if (!platform_reset_in_s || hard_req_q) begin
      st_d  = ST_HARD;
      cnt_d = '0;
    end else begin
      case (st_q)
        ST_POR, ST_HARD: begin
          st_d  = ST_WAIT_CORE;
          cnt_d = '0;
        end
        ST_WAIT_CORE: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CORE_END) begin
            st_d = ST_WAIT_CPU;
          end
        end
        ST_WAIT_CPU: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CPU_END) begin
            st_d = ST_RUN;
          end
        end
        ST_CPU_ONLY: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CPU_END) begin
            st_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (proc_req_q) begin
            st_d  = ST_CPU_ONLY;
            cnt_d = '0;
          end
        end
        default: begin
          st_d  = ST_POR;
          cnt_d = '0;
        end
      endcase
    end
    // processor held whenever not running
    cpu_rst_b_d  = (st_d == ST_RUN);
    // processor-only keeps the core alive
    core_rst_b_d = (st_d == ST_RUN) || (st_d == ST_WAIT_CPU) ||
                   (st_d == ST_CPU_ONLY);
    // refresh depends on core reset only, never on bus-init
    refresh_d    = core_rst_b_d;
  end

  // outputs start at safe levels
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q                  <= ST_POR;
      cnt_q                 <= '0;
      processor_reset_out_b <= 1'b0;
      core_reset_b          <= 1'b0;
      refresh_en            <= 1'b0;
    end else begin
      st_q                  <= st_d;
      cnt_q                 <= cnt_d;
      processor_reset_out_b <= cpu_rst_b_d;
      core_reset_b          <= core_rst_b_d;
      refresh_en            <= refresh_d;
    end
  end

  // ***************************************************************
  // bus-init handling
  // ***************************************************************
  logic bus_reinit_signal_prev_q;
  logic arb_rst_d;
  logic flush_d;

  // touches no register and no port, so links stay up
  always_comb begin
    arb_rst_d = !bus_reinit_signal_b;
    flush_d   = !bus_reinit_signal_b && bus_reinit_signal_prev_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_reinit_signal_prev_q  <= 1'b1;
      fsb_arb_reset <= 1'b0;
      txn_flush     <= 1'b0;
    end else begin
      bus_reinit_signal_prev_q  <= bus_reinit_signal_b;
      fsb_arb_reset <= arb_rst_d;
      txn_flush     <= flush_d;
    end
  end

  // ***************************************************************
  // apb registers
  // ***************************************************************
  logic [NP-1:0]          port_en_q;
  logic [NP-1:0]          port_en_d;
  logic [15:0]            brctl_q [NP];
  logic [15:0]            brctl_d [NP];
  logic [`SRCC_NERR-1:0]  err_q;
  logic [`SRCC_NERR-1:0]  err_d;
  logic                   proc_req_d;
  logic                   hard_req_d;
  logic                   wr;
  logic                   hit;
  logic [31:0]            rdata;
  logic [31:0]            prdata_d;
  logic                   pready_d;
  logic                   pslverr_d;
  logic                   hard_clr;
  srcc_port_ctl_t         pctl [NP];

  // non-sticky state sits at defaults while the core is in reset
  assign hard_clr = !core_reset_b;
  assign wr       = psel && penable && pready && pwrite;

  // read decode and write effects
  always_comb begin
    rdata      = '0;
    hit        = 1'b1;
    port_en_d  = port_en_q;
    proc_req_d = 1'b0;
    hard_req_d = 1'b0;
    err_d      = err_q | err_event_in;
    for (int p = 0; p < NP; p++) begin
      brctl_d[p] = brctl_q[p];
    end
    if (paddr[11:10] == 2'd0) begin
      case (paddr)
        `SRCC_CTRL_ADDR: begin
          rdata[`SRCC_CTRL_EN_LSB +: NP] = port_en_q;
          if (wr) begin
            port_en_d  = pwdata[`SRCC_CTRL_EN_LSB +: NP];
            proc_req_d = pwdata[`SRCC_CTRL_PROC_BIT];
            hard_req_d = pwdata[`SRCC_CTRL_HARD_BIT];
          end
        end
        `SRCC_STAT_ADDR: begin
          rdata[2:0] = {fsb_arb_reset, !core_reset_b,
                        !processor_reset_out_b};
        end
        `SRCC_ERR_ADDR: begin
          rdata[`SRCC_NERR-1:0] = err_q;
          if (wr) begin
            // new events win over the write-one clear
            err_d = (err_q & ~pwdata[`SRCC_NERR-1:0]) | err_event_in;
          end
        end
        default: hit = 1'b0;
      endcase
    end else if (paddr[11:10] <= 2'(NP)) begin
      for (int p = 0; p < NP; p++) begin
        if (paddr[11:10] == 2'(p + 1)) begin
          if (paddr[9:0] == {`SRCC_BRCTL_IDX, 2'b00}) begin
            rdata[15:0] = brctl_q[p];
            if (wr) begin
              brctl_d[p] = pwdata[15:0];
            end
          end else if (paddr[9:0] == {`SRCC_LNKSTS_IDX, 2'b00}) begin
            rdata[`SRCC_LNK_ACT_BIT] = port_sts[p].link_active;
          end else begin
            hit = 1'b0;
          end
        end
      end
    end else begin
      hit = 1'b0;
    end
    if (hard_clr) begin
      port_en_d  = '0;
      proc_req_d = 1'b0;
      hard_req_d = 1'b0;
      for (int p = 0; p < NP; p++) begin
        brctl_d[p] = `SRCC_BRCTL_RST;
      end
    end
    if (!pg_s) begin
      err_d = '0;
    end
    // one wait state, answer registered
    pready_d  = psel && penable && !pready;
    prdata_d  = (pready_d && hit) ? rdata : 32'h0000_0000;
    pslverr_d = pready_d && !hit;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port_en_q  <= '0;
      proc_req_q <= 1'b0;
      hard_req_q <= 1'b0;
      err_q      <= '0;
      pready     <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
      for (int p = 0; p < NP; p++) begin
        brctl_q[p] <= `SRCC_BRCTL_RST;
      end
    end else begin
      port_en_q  <= port_en_d;
      proc_req_q <= proc_req_d;
      hard_req_q <= hard_req_d;
      err_q      <= err_d;
      pready     <= pready_d;
      prdata     <= prdata_d;
      pslverr    <= pslverr_d;
      for (int p = 0; p < NP; p++) begin
        brctl_q[p] <= brctl_d[p];
      end
    end
  end

  // ***************************************************************
  // root ports
  // ***************************************************************
  generate
    for (genvar g = 0; g < NP; g++) begin : g_port
      assign pctl[g].enable  = port_en_q[g];
      assign pctl[g].sec_rst = brctl_q[g][`SRCC_BRCTL_SBR_BIT];

      srcc_port u_port (
        .clk        (clk),
        .rst_b      (rst_b),
        .core_rst_b (core_reset_b),
        .pg_ok      (pg_s),
        .ctl        (pctl[g]),
        .link_up    (link_up_in[g]),
        .sts        (port_sts[g])
      );
    end
  endgenerate

endmodule
